//--- pfc_pkg.sv
/*
  pfc_pkg: constants, register indices, types for the pid feedback
  controller. assumes a 20 mhz single clock and an axi4-lite master.
*/
// Behaviour
// - proportional term linear in error; setting one is 100 percent gain
// - gain has one decimal, or two decimals when gain range bit 1 set
// - integral time zero disables the integral term entirely
// - integral step per error is inverse to integral time, 0 to 100 s
// - integral keeps accumulating every update while error is non-zero, until it reaches its clamp
// - differential term follows only error change; zero when error unchanged
// - differential time 0 to 1 s sets its gain; zero removes it
// - with integral and differential zero, output is proportional term only
// - integral clamped at max frequency times integral limit percent
// - output limited to max frequency times output limit percent
// - comm feedback register used only when source selects 7 or 8
// - source 0 none, 1/4 analog neg/pos, 7/8 comm neg/pos
// - negative feedback: setpoint minus feedback; positive: their sum
`default_nettype none
package pfc_pkg;
  // printed offsets are indices; byte address is index times four
  localparam logic [11:0] IDX_FB_SRC   = 12'h800;
  localparam logic [11:0] IDX_PGAIN    = 12'h801;
  localparam logic [11:0] IDX_ITIME    = 12'h802;
  localparam logic [11:0] IDX_DTIME    = 12'h803;
  localparam logic [11:0] IDX_ILIM     = 12'h804;
  localparam logic [11:0] IDX_OLIM     = 12'h805;
  localparam logic [11:0] IDX_COMM_FB  = 12'h806;
  localparam logic [11:0] IDX_GAIN_CFG = 12'h817;
  localparam logic [11:0] IDX_MAX_FREQ = 12'h100;
  localparam logic [11:0] IDX_SETPOINT = 12'h830;
  localparam logic [11:0] IDX_OUT_PCT  = 12'h831;
  localparam logic [11:0] IDX_FREQ     = 12'h832;
  localparam logic [11:0] IDX_ERROR    = 12'h833;

  localparam logic [15:0] RST_FB_SRC   = 16'h0000;
  localparam logic [15:0] RST_PGAIN    = 16'h000a;
  localparam logic [15:0] RST_ITIME    = 16'h0064;
  localparam logic [15:0] RST_DTIME    = 16'h0000;
  localparam logic [15:0] RST_ILIM     = 16'h03e8;
  localparam logic [15:0] RST_OLIM     = 16'h03e8;
  localparam logic [15:0] RST_COMM_FB  = 16'h0000;
  localparam logic [15:0] RST_GAIN_CFG = 16'h0000;
  localparam logic [15:0] RST_MAX_FREQ = 16'h1770;
  localparam logic [15:0] RST_SETPOINT = 16'h0000;

  localparam int unsigned GAIN_RANGE_BIT = 1;
  localparam logic [15:0] FB_NONE     = 16'h0000;
  localparam logic [15:0] FB_AI_NEG   = 16'h0001;
  localparam logic [15:0] FB_AI_POS   = 16'h0004;
  localparam logic [15:0] FB_COMM_NEG = 16'h0007;
  localparam logic [15:0] FB_COMM_POS = 16'h0008;

  localparam int unsigned CLOCK_HZ         = 20_000_000;
  localparam int unsigned UPDATE_PERIOD_MS = 10;
  localparam int unsigned UPDATE_CYCLES    =
    CLOCK_HZ / 1000 * UPDATE_PERIOD_MS;
  localparam int unsigned ACC_FRAC   = 16;
  localparam int          GAIN_DIV_1 = 10;
  localparam int          GAIN_DIV_2 = 100;
  localparam int          TENTH_TO_HUNDREDTH = 10;
  localparam int          FREQ_DIV   = 10000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_TERMS = 2'b01,
    ST_SUM   = 2'b10,
    ST_OUT   = 2'b11
  } pfc_state_t;

  typedef struct packed {
    logic signed [31:0] p;
    logic signed [31:0] i;
    logic signed [31:0] d;
  } pfc_terms_t;
endpackage : pfc_pkg
`default_nettype wire

//--- pfc_pid_controller.sv
/*
  pfc_pid_controller: pid regulator with axi4-lite register access.
  assumes analog_feedback comes from logic on the same clock, in signed
  0.01 percent units; percentages are 0.01 (setpoint) or 0.1 units.
*/
`timescale 1ns/1ps
`default_nettype none
module pfc_pid_controller #(
  parameter int unsigned UPDATE_CYCLES = pfc_pkg::UPDATE_CYCLES
) (
  input  wire  logic               clock,
  input  wire  logic               resetn,
  input  wire  logic signed [15:0] analog_feedback,
  input  wire  logic [13:0]        s_axi_awaddr,
  input  wire  logic               s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire  logic [31:0]        s_axi_wdata,
  input  wire  logic [3:0]         s_axi_wstrb,
  input  wire  logic               s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire  logic               s_axi_bready,
  input  wire  logic [13:0]        s_axi_araddr,
  input  wire  logic               s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire  logic               s_axi_rready,
  output logic [16:0]              freq_cmd,
  output logic                     pid_active
);
  import pfc_pkg::*;

  logic [15:0]        fb_src_q, pgain_q, itime_q, dtime_q, ilim_q;
  logic [15:0]        olim_q, comm_fb_q, gain_cfg_q, max_freq_q;
  logic signed [15:0] setpoint_q;
  logic               aw_hold_q, w_hold_q;
  logic [11:0]        aw_idx_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic [17:0]        div_cnt_q;
  logic               tick_q;
  pfc_state_t         state_q;
  pfc_terms_t         terms_q;
  logic signed [17:0] err_q, err_prev_q;
  logic signed [47:0] acc_q;
  logic [15:0]        out_pct_q;
  logic [16:0]        freq_q;
  logic               active_q;

  // register write path
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction : merge16

  logic do_write;
  logic wr_known;
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_comb begin
    case (aw_idx_q)
      IDX_FB_SRC, IDX_PGAIN, IDX_ITIME, IDX_DTIME, IDX_ILIM, IDX_OLIM,
      IDX_COMM_FB, IDX_GAIN_CFG, IDX_MAX_FREQ, IDX_SETPOINT:
        wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fb_src_q   <= RST_FB_SRC;
      pgain_q    <= RST_PGAIN;
      itime_q    <= RST_ITIME;
      dtime_q    <= RST_DTIME;
      ilim_q     <= RST_ILIM;
      olim_q     <= RST_OLIM;
      comm_fb_q  <= RST_COMM_FB;
      gain_cfg_q <= RST_GAIN_CFG;
      max_freq_q <= RST_MAX_FREQ;
      setpoint_q <= RST_SETPOINT;
    end else if (do_write) begin
      case (aw_idx_q)
        IDX_FB_SRC:   fb_src_q   <= merge16(fb_src_q, wdata_q, wstrb_q);
        IDX_PGAIN:    pgain_q    <= merge16(pgain_q, wdata_q, wstrb_q);
        IDX_ITIME:    itime_q    <= merge16(itime_q, wdata_q, wstrb_q);
        IDX_DTIME:    dtime_q    <= merge16(dtime_q, wdata_q, wstrb_q);
        IDX_ILIM:     ilim_q     <= merge16(ilim_q, wdata_q, wstrb_q);
        IDX_OLIM:     olim_q     <= merge16(olim_q, wdata_q, wstrb_q);
        IDX_COMM_FB:  comm_fb_q  <= merge16(comm_fb_q, wdata_q, wstrb_q);
        IDX_GAIN_CFG: gain_cfg_q <= merge16(gain_cfg_q, wdata_q, wstrb_q);
        IDX_MAX_FREQ: max_freq_q <= merge16(max_freq_q, wdata_q, wstrb_q);
        IDX_SETPOINT: setpoint_q <= merge16(setpoint_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // axi write channels: address and data latched in either order
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_idx_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_hold_q     <= 1'b1;
        aw_idx_q      <= s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi read channel: one cycle from address to data
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr[13:2])
        IDX_FB_SRC:   s_axi_rdata <= {16'h0000, fb_src_q};
        IDX_PGAIN:    s_axi_rdata <= {16'h0000, pgain_q};
        IDX_ITIME:    s_axi_rdata <= {16'h0000, itime_q};
        IDX_DTIME:    s_axi_rdata <= {16'h0000, dtime_q};
        IDX_ILIM:     s_axi_rdata <= {16'h0000, ilim_q};
        IDX_OLIM:     s_axi_rdata <= {16'h0000, olim_q};
        IDX_COMM_FB:  s_axi_rdata <= {16'h0000, comm_fb_q};
        IDX_GAIN_CFG: s_axi_rdata <= {16'h0000, gain_cfg_q};
        IDX_MAX_FREQ: s_axi_rdata <= {16'h0000, max_freq_q};
        IDX_SETPOINT: s_axi_rdata <= {16'h0000, setpoint_q};
        IDX_OUT_PCT:  s_axi_rdata <= {16'h0000, out_pct_q};
        IDX_FREQ:     s_axi_rdata <= {15'h0000, freq_q};
        IDX_ERROR:    s_axi_rdata <= 32'(err_q);
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // update rate divider
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_cnt_q <= 18'h00000;
      tick_q    <= 1'b0;
    end else if (32'(div_cnt_q) >= UPDATE_CYCLES - 1) begin
      div_cnt_q <= 18'h00000;
      tick_q    <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 18'h00001;
      tick_q    <= 1'b0;
    end
  end

  // feedback selection and error
  logic               src_valid, src_comm, src_pos;
  logic signed [15:0] fb_w;
  logic signed [17:0] err_w;
  assign src_comm  = (fb_src_q == FB_COMM_NEG) ||
                     (fb_src_q == FB_COMM_POS);
  assign src_pos   = (fb_src_q == FB_AI_POS) ||
                     (fb_src_q == FB_COMM_POS);
  assign src_valid = src_comm || src_pos ||
                     (fb_src_q == FB_AI_NEG);
  assign fb_w      = src_comm ? comm_fb_q : analog_feedback;
  // positive feedback adds, taken literally from the sign convention
  assign err_w = src_pos ? 18'(setpoint_q) + 18'(fb_w)
                         : 18'(setpoint_q) - 18'(fb_w);

  // term arithmetic; divisions are by constants except integral time
  logic signed [39:0] p_prod;
  logic signed [31:0] p_w;
  logic signed [47:0] inc_w, acc_sum, acc_lim;
  logic signed [35:0] d_prod;
  logic signed [39:0] sum_w, olim_w;
  assign p_prod = 40'(err_w) * 40'($signed({1'b0, pgain_q}));
  assign p_w = gain_cfg_q[GAIN_RANGE_BIT]
             ? 32'(p_prod / 40'(GAIN_DIV_2))
             : 32'(p_prod / 40'(GAIN_DIV_1));
  // one update per 0.01 s, so step = error / integral time in 0.01 s
  assign inc_w = (48'(err_w) <<< ACC_FRAC) /
                 48'($signed({1'b0, (itime_q == 16'h0000) ? 16'h0001
                                                          : itime_q}));
  assign acc_sum = acc_q + inc_w;
  assign acc_lim = 48'($signed({1'b0, ilim_q})) *
                   48'(TENTH_TO_HUNDREDTH) <<< ACC_FRAC;
  assign d_prod  = 36'(err_w - err_q) *
                   36'($signed({1'b0, dtime_q}));
  assign sum_w   = 40'(terms_q.p) + 40'(terms_q.i) + 40'(terms_q.d);
  assign olim_w  = 40'($signed({1'b0, olim_q})) * 40'(TENTH_TO_HUNDREDTH);

  // control update sequence
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q    <= ST_IDLE;
      terms_q    <= '0;
      err_q      <= 18'h00000;
      err_prev_q <= 18'h00000;
      acc_q      <= 48'h0000_0000_0000;
      out_pct_q  <= 16'h0000;
      freq_q     <= 17'h00000;
      active_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (tick_q && src_valid) begin
            state_q <= ST_TERMS;
          end else if (tick_q) begin
            // no source: controller parked, history dropped
            terms_q    <= '0;
            err_q      <= 18'h00000;
            err_prev_q <= 18'h00000;
            acc_q      <= 48'h0000_0000_0000;
            out_pct_q  <= 16'h0000;
            freq_q     <= 17'h00000;
            active_q   <= 1'b0;
          end
        end
        ST_TERMS: begin
          err_prev_q <= err_q;
          err_q      <= err_w;
          terms_q.p  <= p_w;
          terms_q.d  <= 32'(d_prod);
          if (itime_q == 16'h0000) begin
            acc_q     <= 48'h0000_0000_0000;
            terms_q.i <= 32'h0000_0000;
          end else if (acc_sum > acc_lim) begin
            acc_q     <= acc_lim;
            terms_q.i <= 32'(acc_lim >>> ACC_FRAC);
          end else if (acc_sum < -acc_lim) begin
            acc_q     <= -acc_lim;
            terms_q.i <= 32'((-acc_lim) >>> ACC_FRAC);
          end else begin
            acc_q     <= acc_sum;
            terms_q.i <= 32'(acc_sum >>> ACC_FRAC);
          end
          state_q <= ST_SUM;
        end
        ST_SUM: begin
          // wide sum cannot wrap; saturate into the output window
          if (sum_w > olim_w) begin
            out_pct_q <= 16'(olim_w);
          end else if (sum_w < 40'sh0) begin
            out_pct_q <= 16'h0000;
          end else begin
            out_pct_q <= 16'(sum_w);
          end
          state_q <= ST_OUT;
        end
        ST_OUT: begin
          freq_q   <= 17'((32'(out_pct_q) * 32'(max_freq_q)) /
                          32'(FREQ_DIV));
          active_q <= 1'b1;
          state_q  <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign freq_cmd   = freq_q;
  assign pid_active = active_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic signed [39:0] p_chk;
  assign p_chk = 40'(err_q) * 40'($signed({1'b0, pgain_q}));

  p_gain_a: assert property ((state_q == ST_SUM) &&
      $stable(pgain_q) && $stable(gain_cfg_q) |-> terms_q.p ==
      (gain_cfg_q[GAIN_RANGE_BIT] ? 32'(p_chk / 40'(GAIN_DIV_2))
                                  : 32'(p_chk / 40'(GAIN_DIV_1))))
    else $error("proportional term does not match gain");
  integ_off_a: assert property ((state_q == ST_TERMS) &&
      (itime_q == 16'h0000) |=> acc_q == 48'sh0 && terms_q.i == 32'sh0)
    else $error("integral active with zero integral time");
  integ_step_a: assert property ((state_q == ST_TERMS) &&
      (itime_q != 16'h0000) && (acc_sum <= acc_lim) && (acc_sum >= -acc_lim)
      |=> acc_q == $past(acc_q) + $past(inc_w))
    else $error("integral accumulator did not step");
  integ_clamp_a: assert property ((state_q == ST_SUM) &&
      $stable(ilim_q) |-> acc_q <= acc_lim && acc_q >= -acc_lim)
    else $error("integral accumulator beyond limit");
  diff_zero_a: assert property ((state_q == ST_SUM) &&
      (err_q == err_prev_q) |-> terms_q.d == 32'sh0)
    else $error("differential nonzero with unchanged error");
  diff_off_a: assert property ((state_q == ST_SUM) &&
      $past(dtime_q) == 16'h0000 |-> terms_q.d == 32'sh0)
    else $error("differential nonzero with zero time");
  p_only_a: assert property ((state_q == ST_SUM) &&
      (itime_q == 16'h0000) && (dtime_q == 16'h0000) &&
      $stable(itime_q) && $stable(dtime_q) |-> sum_w == 40'(terms_q.p))
    else $error("output not proportional alone");
  out_limit_a: assert property ((state_q == ST_SUM) |=>
      32'(out_pct_q) <= 32'($past(olim_q)) * 32'(TENTH_TO_HUNDREDTH))
    else $error("output exceeds output limit");
  // comm value is a signed percentage, so it widens by sign
  comm_err_a: assert property ((state_q == ST_TERMS) &&
      (fb_src_q == FB_COMM_NEG) |=> err_q ==
      18'($past(setpoint_q)) - 18'($signed($past(comm_fb_q))))
    else $error("comm feedback not used for error");
  ai_err_a: assert property ((state_q == ST_TERMS) &&
      (fb_src_q == FB_AI_POS) |=>
      err_q == 18'($past(setpoint_q)) + 18'($past(analog_feedback)))
    else $error("analog positive feedback error wrong");
  seq_order_a: assert property ((state_q == ST_IDLE) && tick_q &&
      src_valid |=> state_q == ST_TERMS ##1 state_q == ST_SUM ##1
      state_q == ST_OUT ##1 state_q == ST_IDLE)
    else $error("update sequence out of order");
  idle_src_a: assert property ((state_q == ST_IDLE) && tick_q &&
      !src_valid |=> freq_cmd == 17'h00000 && !pid_active)
    else $error("output not parked without source");

  comm_pos_c: cover property ((state_q == ST_TERMS) &&
      (fb_src_q == FB_COMM_POS));
  integ_clamp_c: cover property ((state_q == ST_TERMS) &&
      (itime_q != 16'h0000) && (acc_sum > acc_lim));
  out_sat_c: cover property ((state_q == ST_SUM) && (sum_w > olim_w));
  p_only_c: cover property ((state_q == ST_SUM) && (itime_q == 16'h0000) &&
      (dtime_q == 16'h0000) && (terms_q.p != 32'sh0));
endmodule : pfc_pid_controller
`default_nettype wire

//--- pfc_sensor_model.sv
/*
  pfc_sensor_model: analog feedback sensor beside the pid block.
  assumes the bench sets the level it should report on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pfc_sensor_model (
  input  wire logic               clock,
  input  wire logic               resetn,
  input  wire logic signed [15:0] level,
  output var  logic signed [15:0] analog_feedback
);
  // registered so the level never changes in the sampling time step
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      analog_feedback <= 16'sh0000;
    end else begin
      analog_feedback <= level;
    end
  end
endmodule : pfc_sensor_model
`default_nettype wire

//--- pid_feedback_controller_test.sv
/*
  pid_feedback_controller_test: register-level tests of the pid block.
  assumes the package constants and a shortened update period of 20.
*/
`timescale 1ns/1ps
`default_nettype none
module pid_feedback_controller_test;
  import pfc_pkg::*;
  localparam int UC = 20;
  logic clock = 1'b0, resetn = 1'b0;
  logic signed [15:0] level = 16'sh0000;
  logic signed [15:0] analog_feedback;
  logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pid_active;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [16:0] freq_cmd;
  logic [31:0] rd, a, b;
  int error_cnt = 0, num_checks = 0, dl [2];
  logic seen;
  logic [11:0] ridx [10] = '{IDX_FB_SRC, IDX_PGAIN, IDX_ITIME, IDX_DTIME,
    IDX_ILIM, IDX_OLIM, IDX_COMM_FB, IDX_GAIN_CFG, IDX_MAX_FREQ,
    IDX_SETPOINT};
  logic [15:0] rval [10] = '{RST_FB_SRC, RST_PGAIN, RST_ITIME, RST_DTIME,
    RST_ILIM, RST_OLIM, RST_COMM_FB, RST_GAIN_CFG, RST_MAX_FREQ,
    RST_SETPOINT};
  always #25 clock = ~clock;
  pfc_sensor_model pfc_sensor_model_inst (.clock(clock), .resetn(resetn),
    .level(level), .analog_feedback(analog_feedback));
  pfc_pid_controller #(.UPDATE_CYCLES(UC)) pfc_pid_controller_inst (
    .clock(clock), .resetn(resetn), .analog_feedback(analog_feedback),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .freq_cmd(freq_cmd),
    .pid_active(pid_active));
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_resp
  task automatic wr(input logic [11:0] idx, input logic [15:0] v,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, v};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    while (s_axi_bvalid !== 1'b1) @(posedge clock);
    s_axi_bready <= 1'b0;
    chk_resp(s_axi_bresp, er);
  endtask : wr
  task automatic rdr(input logic [11:0] idx, output logic [31:0] d,
                     input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clock);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk_resp(s_axi_rresp, er);
  endtask : rdr
  task automatic settle(input int n);
    repeat (n * UC) @(posedge clock);
  endtask : settle
  // p-only case: pct is the expected output percent after the limits
  task automatic p_case(input logic [15:0] src, input int pct);
    wr(IDX_FB_SRC, src, RESP_OKAY);
    settle(3);
    chk_val(32'(freq_cmd), 32'(pct * 6000 / 10000));
  endtask : p_case
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // the whole run is near 2000 cycles; a hang is cut off well past that
  initial begin
    #(50 * 60000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    foreach (ridx[k]) begin
      rdr(ridx[k], rd, RESP_OKAY);
      chk_val(rd, {16'h0000, rval[k]});
    end
    rdr(12'h7ff, rd, RESP_SLVERR);
    chk_val(rd, 32'h0);
    wr(IDX_OUT_PCT, 16'h0001, RESP_SLVERR);
    wr(IDX_ITIME, 16'h0000, RESP_OKAY);
    wr(IDX_SETPOINT, 16'd2000, RESP_OKAY);
    wr(IDX_COMM_FB, 16'd500, RESP_OKAY);
    level <= 16'sd1000;
    p_case(FB_NONE, 0);
    chk_val(32'(pid_active), 32'h0);
    p_case(FB_COMM_NEG, 1500);
    chk_val(32'(pid_active), 32'h1);
    rdr(IDX_ERROR, rd, RESP_OKAY);
    chk_val(rd, 32'd1500);
    wr(IDX_COMM_FB, 16'hfe0c, RESP_OKAY);
    p_case(FB_COMM_NEG, 2500);
    wr(IDX_COMM_FB, 16'd500, RESP_OKAY);
    p_case(FB_COMM_POS, 2500);
    p_case(FB_AI_NEG, 1000);
    p_case(FB_AI_POS, 3000);
    wr(IDX_PGAIN, 16'd5, RESP_OKAY);
    p_case(FB_AI_NEG, 500);
    wr(IDX_GAIN_CFG, 16'h0002, RESP_OKAY);
    wr(IDX_PGAIN, 16'd50, RESP_OKAY);
    p_case(FB_AI_NEG, 500);
    wr(IDX_OLIM, 16'd100, RESP_OKAY);
    p_case(FB_COMM_POS, 1000);
    wr(IDX_SETPOINT, 16'hfc18, RESP_OKAY);
    p_case(FB_AI_NEG, 0);
    wr(IDX_OLIM, 16'd1000, RESP_OKAY);
    wr(IDX_PGAIN, 16'd0, RESP_OKAY);
    wr(IDX_SETPOINT, 16'd1000, RESP_OKAY);
    wr(IDX_COMM_FB, 16'd0, RESP_OKAY);
    // integral alone: longer time must give the slower ramp
    for (int k = 0; k < 2; k++) begin
      p_case(FB_NONE, 0);
      wr(IDX_ITIME, k ? 16'd50 : 16'd100, RESP_OKAY);
      wr(IDX_FB_SRC, FB_COMM_NEG, RESP_OKAY);
      settle(2);
      rdr(IDX_OUT_PCT, a, RESP_OKAY);
      settle(2);
      rdr(IDX_OUT_PCT, b, RESP_OKAY);
      dl[k] = int'(b) - int'(a);
    end
    chk_val(32'(dl[0] > 0), 32'h1);
    chk_val(32'(dl[1] > dl[0]), 32'h1);
    wr(IDX_ILIM, 16'd10, RESP_OKAY);
    settle(30);
    rdr(IDX_OUT_PCT, rd, RESP_OKAY);
    chk_val(rd, 32'd100);
    chk_val(32'(freq_cmd), 32'd60);
    wr(IDX_ITIME, 16'd0, RESP_OKAY);
    p_case(FB_COMM_NEG, 0);
    // differential alone: only a step of the error shows
    for (int k = 0; k < 2; k++) begin
      wr(IDX_DTIME, k ? 16'd0 : 16'd100, RESP_OKAY);
      settle(3);
      chk_val(32'(freq_cmd), 32'h0);
      seen = 1'b0;
      wr(IDX_SETPOINT, k ? 16'd1200 : 16'd1100, RESP_OKAY);
      repeat (3 * UC) begin
        @(posedge clock);
        if (freq_cmd !== 17'h0) seen = 1'b1;
      end
      chk_val(32'(seen), k ? 32'h0 : 32'h1);
      chk_val(32'(freq_cmd), 32'h0);
    end
    tally_and_finish();
  end
endmodule : pid_feedback_controller_test
`default_nettype wire
